// [core/xct_top.sv]
// The AHB-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ps
// Overview of operation
// R1: All members high gives 1 for an even member count, 0 for odd.
// R2: Tester drives all inputs high, then walks one low end to end.
// R3: Each walking low applied to a member inverts the chain output.
// R4: Tester fails the board when an output does not invert.
// R5: Straps settle before power good asserts.
// R6: Entry needs lowest bus-select strap high and test strap low.
// R7: Upper bus-select straps take any defined level during entry.
// R8: Video port control strap pulled high when that port is used.
// R9: Lane chain members follow coexist, control and reversal straps.
// R10: Fifteen chains, each driving its own output pin.
// R11: Full-width testing shows each chain on both its pins.
// R12: Outputs follow inputs; mode holds until power good drops.
module xct_top (
  input  wire logic                                            ref_clk,
  input  wire logic                                            rst,
  input  wire logic                                            ce,
  input  wire logic                                            power_good,
  input  wire logic                                            video_port_control_strap,
  input  wire logic [xct_pkg::LANE_CHAIN-1:0][xct_pkg::CHAIN_W-1:0] chain_in,
  input  wire logic [xct_pkg::LANE_W-1:0]                      lane_receive_pos,
  input  wire logic [xct_pkg::LANE_W-1:0]                      lane_receive_neg,
  input  wire logic [xct_pkg::LANE_W-1:0]                      lane_transmit_pos,
  input  wire logic [xct_pkg::LANE_W-1:0]                      lane_transmit_neg,
  input  wire logic [xct_pkg::NCHAIN-1:0]                      test_pin_i,
  output logic      [xct_pkg::NCHAIN-1:0]                      test_pin_o,
  output logic      [xct_pkg::NCHAIN-1:0]                      test_pin_oe_n,
  output logic      [xct_pkg::NCHAIN-1:0]                      mirror_pin_o,
  output logic      [xct_pkg::NCHAIN-1:0]                      mirror_pin_oe_n,
  input  wire logic                                            hsel,
  input  wire logic [31:0]                                     haddr,
  input  wire logic [1:0]                                      htrans,
  input  wire logic                                            hwrite,
  input  wire logic [2:0]                                      hsize,
  input  wire logic [31:0]                                     hwdata,
  input  wire logic                                            hready,
  output logic      [31:0]                                     hrdata,
  output logic                                                 hreadyout,
  output logic                                                 hresp
);

  logic                   pg_q;
  logic                   mode_q;
  logic                   mode_d;
  xct_pkg::xct_strap_s    strap_q;
  logic [31:0]            ctrl_q;
  xct_pkg::xct_aphase_s   aph_q;
  logic [xct_pkg::LANE_W-1:0]  lane_mask16;
  logic [xct_pkg::CHAIN_W-1:0] lane_in;
  logic [xct_pkg::CHAIN_W-1:0] lane_mask;
  logic                   en_hi;
  logic                   en_lo;
  logic [31:0]            rd_d;

  // Entry decode: lowest bus select high and test strap low at the power-good edge
  assign mode_d = test_pin_i[xct_pkg::PIN_BUS_SEL0] & ~test_pin_i[xct_pkg::PIN_TREE_TEST]; // R6

  // Power-good edge catches straps; falling power good leaves the mode
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pg_q    <= 1'b0;
      mode_q  <= 1'b0;
      strap_q <= xct_pkg::STRAP_RESET;
    end else if (ce) begin
      pg_q <= power_good;
      if (!power_good) begin
        mode_q <= 1'b0; // R12
      end else if (!pg_q) begin
        mode_q  <= mode_d; // R6
        strap_q <= '{bus_select_strap:          {test_pin_i[xct_pkg::PIN_BUS_SEL2],
                                                 test_pin_i[xct_pkg::PIN_BUS_SEL1],
                                                 test_pin_i[xct_pkg::PIN_BUS_SEL0]},
                     video_port_control_strap:  video_port_control_strap,
                     lane_coexist_enable_strap: test_pin_i[xct_pkg::PIN_LANE_COEX],
                     lane_reversal_strap:       test_pin_i[xct_pkg::PIN_LANE_REV]};
      end
    end
  end

  // Lane membership; with neither control nor coexist set no lane is a member
  assign en_hi       = strap_q.lane_coexist_enable_strap |
                       (strap_q.video_port_control_strap & ~strap_q.lane_reversal_strap); // R9
  assign en_lo       = strap_q.lane_coexist_enable_strap |
                       (strap_q.video_port_control_strap & strap_q.lane_reversal_strap); // R9
  assign lane_mask16 = {{8{en_hi}}, {8{en_lo}}};
  assign lane_mask   = {4{lane_mask16}};
  assign lane_in     = {lane_transmit_neg, lane_transmit_pos, lane_receive_neg, lane_receive_pos};

  // One tree per chain, each on its own pin
  genvar g;
  generate
    for (g = 0; g < xct_pkg::NCHAIN; g++) begin : g_chain
      logic [xct_pkg::CHAIN_W-1:0] in_g;
      logic [xct_pkg::CHAIN_W-1:0] mask_g;
      if (g == xct_pkg::LANE_CHAIN) begin : g_lane
        assign in_g   = lane_in;
        assign mask_g = lane_mask; // R9
      end else begin : g_fixed
        assign in_g   = chain_in[g];
        assign mask_g = {xct_pkg::CHAIN_W{1'b1}} >> (xct_pkg::CHAIN_W - xct_pkg::CHAIN_LEN[g]);
      end
      xct_tree #(
        .W (xct_pkg::CHAIN_W)
      ) u_tree (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .ce        (ce),
        .en        (mode_q),
        .mirror_en (ctrl_q[xct_pkg::CTRL_MIRROR_BIT]),
        .in        (in_g),
        .mask      (mask_g),
        .out_q     (test_pin_o[g]),
        .mirror_q  (mirror_pin_o[g])
      ); // R1 R3 R10 R11 R12
    end
  endgenerate

  // Pins are released until the mode is entered so straps can be read
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      test_pin_oe_n   <= '1;
      mirror_pin_oe_n <= '1;
    end else if (ce) begin
      test_pin_oe_n   <= {xct_pkg::NCHAIN{~mode_q}}; // R10
      mirror_pin_oe_n <= {xct_pkg::NCHAIN{~(mode_q & ctrl_q[xct_pkg::CTRL_MIRROR_BIT])}}; // R11
    end
  end

  // Read mux, sampled at the address phase so data stand in the data phase
  always_comb begin
    rd_d = 32'h0000_0000;
    case (haddr[11:0])
      xct_pkg::OFF_CTRL:   rd_d = ctrl_q;
      xct_pkg::OFF_STATUS: rd_d = {25'h000_0000, strap_q.lane_reversal_strap, strap_q.bus_select_strap,
                                   strap_q.video_port_control_strap, strap_q.lane_coexist_enable_strap, mode_q};
      xct_pkg::OFF_CHAINS: rd_d = {17'h0_0000, test_pin_o};
      default:             rd_d = 32'h0000_0000;
    endcase
  end

  // Zero-wait slave: address phase captured, write done in the data phase
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      aph_q     <= xct_pkg::APHASE_RESET;
      hrdata    <= xct_pkg::RDATA_RESET;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (ce) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (hready) begin
        aph_q.valid <= hsel & htrans[xct_pkg::HTRANS_ACTIVE_BIT];
        aph_q.write <= hwrite;
        aph_q.addr  <= haddr[11:0];
        if (hsel && htrans[xct_pkg::HTRANS_ACTIVE_BIT] && !hwrite) begin
          hrdata <= rd_d;
        end
      end
    end
  end

  // Control register; only the mirror enable is writable
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= xct_pkg::CTRL_RESET;
    end else if (ce && aph_q.valid && aph_q.write && aph_q.addr == xct_pkg::OFF_CTRL) begin
      ctrl_q <= {31'h0000_0000, hwdata[xct_pkg::CTRL_MIRROR_BIT]};
    end
  end

  // Chain results follow the members one edge later
  a_all_high_parity: assert property (@(posedge ref_clk) disable iff (rst) // R1
    (ce && mode_q && &chain_in[0]) |=> test_pin_o[0] == 1'b1)
    else $error("even chain all high must read 1");
  a_odd_all_high: assert property (@(posedge ref_clk) disable iff (rst) // R1
    (ce && mode_q && &chain_in[3][12:0]) |=> test_pin_o[3] == 1'b0)
    else $error("odd chain all high must read 0");
  a_chain_parity: assert property (@(posedge ref_clk) disable iff (rst) // R1
    (ce && mode_q) |=> test_pin_o[2] == ~^($past(chain_in[2][13:0])))
    else $error("chain output parity wrong");
  a_walk_toggle: assert property (@(posedge ref_clk) disable iff (rst) // R3
    (ce && mode_q && $past(ce) && $past(mode_q) && $onehot(chain_in[0] ^ $past(chain_in[0])))
    |=> test_pin_o[0] != $past(test_pin_o[0])) else $error("output did not invert on walk");

  // Lane membership from the captured straps
  a_lane_reverse: assert property (@(posedge ref_clk) disable iff (rst) // R9
    (mode_q && strap_q.video_port_control_strap && !strap_q.lane_coexist_enable_strap
     && strap_q.lane_reversal_strap) |-> lane_mask == {4{16'h00ff}}) else $error("lane half wrong");
  a_lane_normal: assert property (@(posedge ref_clk) disable iff (rst) // R9
    (!strap_q.lane_coexist_enable_strap && strap_q.video_port_control_strap && !strap_q.lane_reversal_strap)
    |-> lane_mask == {4{16'hff00}}) else $error("lane upper half wrong");
  a_lane_all: assert property (@(posedge ref_clk) disable iff (rst) // R9
    strap_q.lane_coexist_enable_strap |-> lane_mask == {xct_pkg::CHAIN_W{1'b1}})
    else $error("lane chain not full width");
  a_lane_empty: assert property (@(posedge ref_clk) disable iff (rst) // R9
    (!strap_q.lane_coexist_enable_strap && !strap_q.video_port_control_strap) |-> lane_mask == '0)
    else $error("unused lanes counted in chain");

  // Pin release, mirror copy and mode lifetime
  a_pins_driven: assert property (@(posedge ref_clk) disable iff (rst) // R10
    (ce && mode_q) |=> test_pin_oe_n == '0)
    else $error("chain pins not driven in mode");
  a_pins_released: assert property (@(posedge ref_clk) disable iff (rst) // R12
    (ce && !mode_q) |=> (test_pin_oe_n == '1 && test_pin_o == '0))
    else $error("chain pins not released outside mode");
  a_mirror_copy: assert property (@(posedge ref_clk) disable iff (rst) // R11
    (ce && mode_q && ctrl_q[xct_pkg::CTRL_MIRROR_BIT]) |=> mirror_pin_o == test_pin_o)
    else $error("mirror pin differs");
  a_mirror_off: assert property (@(posedge ref_clk) disable iff (rst) // R11
    (ce && !ctrl_q[xct_pkg::CTRL_MIRROR_BIT]) |=> (mirror_pin_o == '0 && mirror_pin_oe_n == '1))
    else $error("mirror pins active while disabled");
  a_entry_taken: assert property (@(posedge ref_clk) disable iff (rst) // R6
    (ce && power_good && !pg_q) |=> mode_q == $past(mode_d))
    else $error("entry decode not applied at power good");
  a_mode_hold: assert property (@(posedge ref_clk) disable iff (rst) // R12
    (ce && mode_q && power_good) |=> mode_q)
    else $error("mode left while power good high");
  a_strap_hold: assert property (@(posedge ref_clk) disable iff (rst) // R12
    (ce && pg_q) |=> $stable(strap_q))
    else $error("straps moved after capture");
  a_mode_exit: assert property (@(posedge ref_clk) disable iff (rst) // R12
    (ce && !power_good) |=> !mode_q ##1 (!$past(ce) || test_pin_oe_n == '1))
    else $error("mode kept after power drop");

  // Register bus never stalls and always answers okay
  a_bus_okay: assert property (@(posedge ref_clk) disable iff (rst)
    hreadyout && !hresp)
    else $error("bus slave stalled or erred");

endmodule

// [core/xct_pkg.sv]
package xct_pkg;

  // Chain geometry
  localparam int NCHAIN     = 15;
  localparam int CHAIN_W    = 64;
  localparam int LANE_CHAIN = 14;
  localparam int LANE_W     = 16;

  // Member count of each fixed chain (index 0..13); unknown lists use a plain default
  localparam int CHAIN_LEN [LANE_CHAIN] = '{64, 40, 14, 13, 31, 20, 64, 12, 21, 16, 16, 16, 16, 16};

  // Pin slots of the shared strap / chain output pins
  localparam int PIN_ALL_FLOAT  = 0;
  localparam int PIN_TREE_TEST  = 1;
  localparam int PIN_HUB_SYNC   = 2;
  localparam int PIN_BUS_SEL1   = 6;
  localparam int PIN_BUS_SEL2   = 7;
  localparam int PIN_LANE_REV   = 10;
  localparam int PIN_LANE_COEX  = 11;
  localparam int PIN_MEM_TYPE   = 12;
  localparam int PIN_BUS_SEL0   = 14;

  // Register byte offsets
  localparam logic [11:0] OFF_CTRL   = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_CHAINS = 12'h008;

  // Field positions and reset values
  localparam int          CTRL_MIRROR_BIT = 0;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0001;
  localparam logic [31:0] RDATA_RESET     = 32'h0000_0000;

  // AHB transfer type bit that marks an active transfer
  localparam int HTRANS_ACTIVE_BIT = 1;

  // Straps caught at the power-good edge
  typedef struct packed {
    logic [2:0] bus_select_strap;
    logic       video_port_control_strap;
    logic       lane_coexist_enable_strap;
    logic       lane_reversal_strap;
  } xct_strap_s;

  localparam xct_strap_s STRAP_RESET = '0;

  // Captured AHB address phase
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [11:0] addr;
  } xct_aphase_s;

  localparam xct_aphase_s APHASE_RESET = '0;

endpackage

// [core/xct_tree.sv]
`timescale 1ns/1ps
// One XOR tree with a registered result and a registered mirror copy
module xct_tree #(
  parameter int W = 64
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic         en,
  input  wire logic         mirror_en,
  input  wire logic [W-1:0] in,
  input  wire logic [W-1:0] mask,
  output logic              out_q,
  output logic              mirror_q
);

  logic parity;

  // Non-members masked to 0; the final inverter makes an even all-high chain read 1
  assign parity = ~^(in & mask); // R1 R3

  // Registered so the pin is glitch free; costs one clock of latency
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      out_q    <= 1'b0;
      mirror_q <= 1'b0;
    end else if (ce) begin
      out_q    <= en & parity;
      mirror_q <= en & mirror_en & parity;
    end
  end

endmodule

// [verification/xct_tester.sv]
`timescale 1ns/1ps
// Board tester: owns power good, the straps and the shared pin levels
module xct_tester (
  input  wire logic [14:0] test_pin_o,
  input  wire logic [14:0] test_pin_oe_n,
  input  wire logic        ref_clk,
  output logic             power_good,
  output logic             video_port_control_strap,
  output logic [14:0]      test_pin_i
);
  logic [14:0] pin_drv;

  // Device owns a pin only while its enable is low
  assign test_pin_i = (test_pin_oe_n & pin_drv) | (~test_pin_oe_n & test_pin_o);

  initial begin
    power_good = 1'b0;
    video_port_control_strap = 1'b0;
    pin_drv = 15'h2a5a;
  end

  // Straps settle well before power good rises; late moves are lost anyway
  task automatic boot(input logic [2:0] bs, input logic tt, vc, cx, rv);
    @(posedge ref_clk);
    power_good <= 1'b0;
    pin_drv[14] <= bs[0];
    pin_drv[7:6] <= bs[2:1];
    pin_drv[1] <= tt;
    pin_drv[11:10] <= {cx, rv};
    video_port_control_strap <= vc;
    repeat (3) @(posedge ref_clk);
    power_good <= 1'b1;
    repeat (4) @(posedge ref_clk);
  endtask

  // Power good and video strap moved outside a boot; only this model drives them
  task automatic set_pins(input logic pg, input logic vc);
    power_good <= pg;
    video_port_control_strap <= vc;
  endtask
endmodule

// [verification/xct_top_tb.sv]
`timescale 1ns/1ps
// Self-checking bench for the tree test block
module xct_top_tb;
  localparam int NL = xct_pkg::LANE_CHAIN;
  logic ref_clk = 1'b0, rst = 1'b1, ce = 1'b1, hsel = 1'b1, hwrite = 1'b0;
  logic                power_good, video_port_control_strap, hreadyout, hresp, ah;
  logic [NL-1:0][63:0] chain_in = '0;
  logic [15:0]         rxp = '0, rxn = '0, txp = '0, txn = '0;
  logic [14:0]         pin_i, pin_o, pin_oe_n, mir_o, mir_oe_n, e;
  logic [31:0]         haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0]          htrans = 2'b00;
  logic [2:0]          hsize = 3'b010;
  integer seed = 95, num_errors = 0, n_compared = 0;

  xct_top uut (.ref_clk(ref_clk), .rst(rst), .ce(ce), .power_good(power_good),
    .video_port_control_strap(video_port_control_strap), .chain_in(chain_in), .lane_receive_pos(rxp),
    .lane_receive_neg(rxn), .lane_transmit_pos(txp), .lane_transmit_neg(txn), .test_pin_i(pin_i),
    .test_pin_o(pin_o), .test_pin_oe_n(pin_oe_n), .mirror_pin_o(mir_o), .mirror_pin_oe_n(mir_oe_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
  xct_tester tst (.ref_clk(ref_clk), .test_pin_o(pin_o), .test_pin_oe_n(pin_oe_n), .power_good(power_good),
    .video_port_control_strap(video_port_control_strap), .test_pin_i(pin_i));

  always #25 ref_clk = ~ref_clk;

  // Reference trees; c is {video, coexist, reversal}; empty chain reads as even
  function automatic logic [14:0] expect_out(input logic [2:0] c);
    logic [15:0] m;
    expect_out = '0;
    for (int g = 0; g < NL; g++) expect_out[g] = ~^(chain_in[g] & ((65'd1 << xct_pkg::CHAIN_LEN[g]) - 1));
    m = c[1] ? 16'hffff : (c[2] ? (c[0] ? 16'h00ff : 16'hff00) : 16'h0000);
    expect_out[14] = ~^{txn & m, txp & m, rxn & m, rxp & m};
  endfunction

  task automatic chk(input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      $display("[FAIL] %0t ns got %h exp %h", $time, got, exp);
      num_errors++;
    end
  endtask

  // Single word transfer; waits on hready, read data taken at the data edge
  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    haddr <= {20'h0_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // Random members, result checked one edge later on both pin sets
  task automatic vec(input logic [2:0] c);
    @(posedge ref_clk);
    for (int g = 0; g < NL; g++) chain_in[g] <= {$random(seed), $random(seed)};
    {rxp, rxn, txp, txn} <= {$random(seed), $random(seed)};
    @(posedge ref_clk);
    #1;
    e = expect_out(c);
    chk(pin_o, e);
    chk(mir_o, e);
  endtask

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Cut-off far beyond the few hundred cycles the run needs
  initial begin
    #400000;
    num_errors++;
    complete_run();
  end

  // Main sequence
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    chk(pin_oe_n, 15'h7fff);
    ahb(1'b0, xct_pkg::OFF_CTRL, '0);
    chk(rd, xct_pkg::CTRL_RESET);
    // Entry refused with test strap high, then with lowest bus select low
    tst.boot(3'b001, 1'b1, 1'b0, 1'b1, 1'b0);
    chk(pin_oe_n, 15'h7fff);
    tst.boot(3'b110, 1'b0, 1'b0, 1'b1, 1'b0);
    chk(pin_oe_n, 15'h7fff);
    $display("entry refusal test done");
    // Every strap set of the lane chain, upper bus selects random
    for (int k = 0; k < 8; k++) begin
      tst.boot({2'($random(seed)), 1'b1}, 1'b0, k[2], k[1], k[0]);
      #1;
      chk(pin_oe_n, 15'h0000);
      chk(mir_oe_n, 15'h0000);
      repeat (6) vec(k[2:0]);
      $display("lane strap set %0d done", k);
    end
    // All members high, then one low walked end to end
    tst.boot(3'b001, 1'b0, 1'b0, 1'b1, 1'b0);
    chain_in <= '1;
    {rxp, rxn, txp, txn} <= '1;
    repeat (2) @(posedge ref_clk);
    #1;
    ah = pin_o[0];
    chk(ah, 1'b1);
    chk(pin_o, expect_out(3'b010));
    for (int i = 0; i < 64; i++) begin
      @(posedge ref_clk);
      chain_in <= {NL{~(64'd1 << i)}};
      {rxp, rxn, txp, txn} <= ~(64'd1 << i);
      @(posedge ref_clk);
      #1;
      chk(pin_o[0], !ah);
      chk(pin_o, expect_out(3'b010));
      // Back to all high so every step is a single-member change
      @(posedge ref_clk);
      chain_in <= '1;
      {rxp, rxn, txp, txn} <= '1;
    end
    $display("walking low test done");
    // Strap moved in mode is ignored; status and chain words read back
    tst.boot(3'b101, 1'b0, 1'b1, 1'b0, 1'b0);
    tst.set_pins(1'b1, 1'b0);
    vec(3'b100);
    // Clock enable low freezes the chain pins while the members move
    @(posedge ref_clk);
    ce <= 1'b0;
    chain_in <= ~chain_in;
    repeat (3) @(posedge ref_clk);
    #1;
    chk(pin_o, e);
    @(posedge ref_clk);
    ce <= 1'b1;
    chain_in <= ~chain_in;
    ahb(1'b0, xct_pkg::OFF_STATUS, '0);
    chk(rd, 32'h0000_002d);
    ahb(1'b0, xct_pkg::OFF_CHAINS, '0);
    chk(rd, {17'h0_0000, e});
    ahb(1'b1, xct_pkg::OFF_CTRL, 32'h0000_0000);
    repeat (2) @(posedge ref_clk);
    #1;
    chk(mir_oe_n, 15'h7fff);
    chk(mir_o, 15'h0000);
    chk(pin_oe_n, 15'h0000);
    ahb(1'b1, 12'h100, 32'hffff_ffff);
    ahb(1'b0, 12'h100, '0);
    chk(rd, 32'h0000_0000);
    chk({hreadyout, hresp}, 2'b10);
    ahb(1'b0, xct_pkg::OFF_CTRL, '0);
    chk(rd, 32'h0000_0000);
    $display("register test done");
    // Power good drop leaves the mode
    @(posedge ref_clk);
    tst.set_pins(1'b0, 1'b0);
    repeat (3) @(posedge ref_clk);
    #1;
    chk(pin_oe_n, 15'h7fff);
    chk(pin_o, 15'h0000);
    $display("power drop test done");
    complete_run();
  end
endmodule
